// ---- serial_flash_command_decoder.sv ----
// Serial flash command framing, decoding, status bits and page data FIFO
`timescale 1ns/1ps
`include "sfd_cfg.svh"

module sfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = cnt_r != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];

  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem_r[wp_r] <= i_in_data;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfd_fifo

module serial_flash_command_decoder import sfd_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic i_write_in_progress,
  input wire logic i_op_done,
  output logic [23:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_strobe,
  output logic o_exec_valid,
  output logic [7:0] o_exec_code,
  output logic [23:0] o_exec_addr,
  output logic o_reject,
  output logic [7:0] o_pp_data,
  output logic o_pp_valid,
  input wire logic i_pp_ready,
  output logic o_pp_overrun,
  output logic [7:0] o_wrap_cfg,
  output logic [15:0] o_status
);
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sclk_d_r;
  logic cs_d_r;
  state_t state_r;
  state_t state_nxt;
  state_t tail_st;
  logic [4:0] ph_cnt_r;
  logic [4:0] cnt_nxt;
  logic [4:0] tail_cnt;
  logic [7:0] op_r;
  cmd_info_t info_r;
  cmd_info_t dec_w;
  logic [23:0] addr_r;
  logic [7:0] din_sh_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] sr_lo_r;
  logic [7:0] sr_hi_r;
  logic [2:0] clk_mod_r;
  logic [7:0] out_sh_r;
  logic [4:0] out_cnt_r;
  logic [4:0] bp_r;
  logic [1:0] lock_r;
  logic srp0_r, srp1_r, qe_r, cmp_r, dmy_cfg_r, susp_r, wel_r;
  logic vol_en_r, rst_arm_r;
  logic fifo_in_ready;

  function automatic logic [4:0] lane_clks(input lane_t w,
                                           input logic [5:0] bits);
    return 5'((bits >> w) - 6'd1);
  endfunction : lane_clks

  function automatic cmd_info_t decode(input logic [7:0] op);
    cmd_info_t c;
    c = '0;
    case (op)
      `OP_WR_EN, `OP_WR_DIS, `OP_VOL_EN, `OP_RST_EN, `OP_RST, `OP_SUSPEND,
      `OP_RESUME, `OP_PWR_DN:
        c.exec = 1'b1;
      `OP_CE_A, `OP_CE_B:
        c = '{1'b0, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b0, 2'd0, 1'b0, 2'd0,
              1'b1, 1'b1};
      `OP_WR_SR:
        c = '{1'b0, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b1, 2'd0, 1'b0, 2'd0,
              1'b1, 1'b1};
      `OP_RD_SR_LO, `OP_RD_SR_HI, `OP_JEDEC_ID:
        c.dout = 1'b1;
      `OP_READ, `OP_MFG_ID, `OP_PWR_UP:
        c = '{1'b1, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b0, 2'd0, 1'b1, 2'd0,
              1'b0, 1'b0};
      `OP_FAST, `OP_UID, `OP_SEC_RD, `OP_SFDP:
        c = '{1'b1, 2'd0, 1'b0, `DMY_BYTE, 1'b0, 1'b0, 2'd0, 1'b1, 2'd0,
              1'b0, 1'b0};
      `OP_DUAL_OUT:
        c = '{1'b1, 2'd0, 1'b0, `DMY_BYTE, 1'b0, 1'b0, 2'd0, 1'b1, 2'd1,
              1'b0, 1'b0};
      `OP_QUAD_OUT:
        c = '{1'b1, 2'd0, 1'b0, `DMY_BYTE, 1'b0, 1'b0, 2'd0, 1'b1, 2'd2,
              1'b0, 1'b0};
      `OP_DUAL_IO:
        c = '{1'b1, 2'd1, 1'b1, `DMY_NONE, 1'b1, 1'b0, 2'd0, 1'b1, 2'd1,
              1'b0, 1'b0};
      `OP_QUAD_IO:
        c = '{1'b1, 2'd2, 1'b1, `DMY_QIO, 1'b1, 1'b0, 2'd0, 1'b1, 2'd2,
              1'b0, 1'b0};
      `OP_WRAP:
        c = '{1'b1, 2'd2, 1'b0, `DMY_NONE, 1'b0, 1'b1, 2'd2, 1'b0, 2'd0,
              1'b1, 1'b0};
      `OP_PP, `OP_SEC_PR:
        c = '{1'b1, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b1, 2'd0, 1'b0, 2'd0,
              1'b1, 1'b1};
      `OP_QPP:
        c = '{1'b1, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b1, 2'd2, 1'b0, 2'd0,
              1'b1, 1'b1};
      `OP_SE, `OP_BE32, `OP_BE64, `OP_SEC_ER:
        c = '{1'b1, 2'd0, 1'b0, `DMY_NONE, 1'b0, 1'b0, 2'd0, 1'b0, 2'd0,
              1'b1, 1'b1};
      default:
        c = '0;
    endcase
    return c;
  endfunction : decode

  // Link pins are asynchronous to the core clock
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_r <= 6'h20;
      sync2_r <= 6'h20;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {i_cs_n, i_sclk, i_io};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[4];
      cs_d_r <= sync2_r[5];
    end
  end

  wire cs_n_s = sync2_r[5];
  wire [3:0] io_s = sync2_r[3:0];
  wire sclk_rise = sync2_r[4] && !sclk_d_r && !cs_n_s;
  wire sclk_fall = !sync2_r[4] && sclk_d_r && !cs_n_s;
  wire cs_rise = cs_n_s && !cs_d_r;
  wire cs_fall = !cs_n_s && cs_d_r;
  wire [7:0] op_nxt = {op_r[6:0], io_s[0]};
  assign dec_w = decode(op_nxt);
  wire lane_t cur_w = (state_r == ST_DIN) ? info_r.dw : info_r.aw;
  wire [23:0] addr_sh = (cur_w == 2'd2) ? {addr_r[19:0], io_s} :
                        (cur_w == 2'd1) ? {addr_r[21:0], io_s[1:0]} :
                        {addr_r[22:0], io_s[0]};
  wire [7:0] din_sh = (cur_w == 2'd2) ? {din_sh_r[3:0], io_s} :
                      (cur_w == 2'd1) ? {din_sh_r[5:0], io_s[1:0]} :
                      {din_sh_r[6:0], io_s[0]};
  // Extra dummy clocks only for the dual and quad I/O reads
  wire [4:0] dmy_clks = info_r.dmy +
    ((info_r.dmy_ext && dmy_cfg_r) ? `DMY_EXTRA : `DMY_NONE);
  wire counting = state_r inside {ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY,
                                  ST_DIN};
  wire byte_done = sclk_rise && state_r == ST_DIN && ph_cnt_r == 5'd0;
  wire is_pp = op_r inside {`OP_PP, `OP_QPP, `OP_SEC_PR};
  wire load_ev = sclk_fall && state_r == ST_DOUT && out_cnt_r == 5'd0;
  wire sr_src = op_r inside {`OP_RD_SR_LO, `OP_RD_SR_HI};
  wire [7:0] src_byte = (op_r == `OP_RD_SR_LO) ? o_status[7:0] :
                        (op_r == `OP_RD_SR_HI) ? o_status[15:8] :
                        i_rd_data;

  // Common tail after the address or mode bytes
  always_comb
  begin
    tail_st = ST_END;
    tail_cnt = 5'd0;
    if (dmy_clks != `DMY_NONE)
    begin
      tail_st = ST_DUMMY;
      tail_cnt = dmy_clks - 5'd1;
    end
    else if (info_r.din)
    begin
      tail_st = ST_DIN;
      tail_cnt = lane_clks(info_r.dw, `BYTE_BITS);
    end
    else if (info_r.dout)
      tail_st = ST_DOUT;
  end

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = ph_cnt_r;
    if (cs_fall)
    begin
      state_nxt = ST_OPC;
      cnt_nxt = 5'd7;
    end
    else if (cs_n_s)
      state_nxt = ST_IDLE;
    else if (sclk_rise && counting && ph_cnt_r != 5'd0)
      cnt_nxt = ph_cnt_r - 5'd1;
    else if (sclk_rise)
    begin
      unique case (state_r)
        ST_OPC:
        begin
          if (dec_w.has_addr)
          begin
            state_nxt = ST_ADDR;
            cnt_nxt = lane_clks(dec_w.aw, `ADDR_BITS);
          end
          else if (dec_w.din)
          begin
            state_nxt = ST_DIN;
            cnt_nxt = lane_clks(dec_w.dw, `BYTE_BITS);
          end
          else if (dec_w.dout)
            state_nxt = ST_DOUT;
          else if (dec_w.exec)
            state_nxt = ST_END;
          else
            state_nxt = ST_IGNORE;
        end
        ST_ADDR:
        begin
          state_nxt = info_r.has_mode ? ST_MODE : tail_st;
          cnt_nxt = info_r.has_mode ? lane_clks(info_r.aw, `BYTE_BITS) :
                    tail_cnt;
        end
        ST_MODE:
        begin
          state_nxt = tail_st;
          cnt_nxt = tail_cnt;
        end
        ST_DUMMY:
          state_nxt = ST_DOUT;
        ST_DIN:
          cnt_nxt = lane_clks(info_r.dw, `BYTE_BITS);
        ST_IDLE, ST_DOUT, ST_END, ST_IGNORE:
          state_nxt = state_r;
        default:
          state_nxt = ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= ST_IDLE;
      ph_cnt_r <= 5'd0;
    end
    else
    begin
      state_r <= state_nxt;
      ph_cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      op_r <= 8'h00;
      info_r <= '0;
      addr_r <= 24'h000000;
      din_sh_r <= 8'h00;
      byte_cnt_r <= 2'd0;
      sr_lo_r <= 8'h00;
      sr_hi_r <= 8'h00;
      clk_mod_r <= 3'd0;
    end
    else if (cs_fall)
    begin
      info_r <= '0;
      byte_cnt_r <= 2'd0;
      clk_mod_r <= 3'd0;
    end
    else if (sclk_rise)
    begin
      clk_mod_r <= clk_mod_r + 3'd1;
      if (state_r == ST_OPC)
        op_r <= op_nxt;
      if (state_r == ST_OPC && ph_cnt_r == 5'd0)
        info_r <= dec_w;
      if (state_r == ST_ADDR)
        addr_r <= addr_sh;
      if (state_r == ST_DIN)
        din_sh_r <= din_sh;
      if (byte_done && byte_cnt_r != 2'd3)
        byte_cnt_r <= byte_cnt_r + 2'd1;
      if (byte_done && byte_cnt_r == 2'd0)
        sr_lo_r <= din_sh;
      if (byte_done && byte_cnt_r == 2'd1)
        sr_hi_r <= din_sh;
    end
    else if (load_ev && !sr_src)
      addr_r <= addr_r + 24'h000001;
  end

  // Output bits change on falling SCLK so the host samples them stable
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      out_sh_r <= 8'h00;
      out_cnt_r <= 5'd0;
      o_io_oe <= 4'h0;
      o_rd_strobe <= 1'b0;
    end
    else
    begin
      o_rd_strobe <= load_ev && !sr_src;
      if (cs_n_s)
      begin
        out_cnt_r <= 5'd0;
        o_io_oe <= 4'h0;
      end
      else if (load_ev)
      begin
        out_sh_r <= src_byte;
        out_cnt_r <= lane_clks(info_r.ow, `BYTE_BITS);
        o_io_oe <= (info_r.ow == 2'd2) ? 4'hf :
                   (info_r.ow == 2'd1) ? 4'h3 : 4'h2;
      end
      else if (sclk_fall && state_r == ST_DOUT)
      begin
        out_sh_r <= out_sh_r << (3'd1 << info_r.ow);
        out_cnt_r <= out_cnt_r - 5'd1;
      end
    end
  end

  assign o_io = (info_r.ow == 2'd2) ? out_sh_r[7:4] :
                (info_r.ow == 2'd1) ? {2'b00, out_sh_r[7:6]} :
                {2'b00, out_sh_r[7], 1'b0};
  assign o_rd_addr = addr_r;

  // A frame completes at the end state or after whole data bytes, one or two of them for a status write
  wire complete = state_r == ST_END || (state_r == ST_DIN &&
    byte_cnt_r != 2'd0 && !(op_r == `OP_WR_SR && byte_cnt_r == 2'd3));
  wire frame_ok = cs_rise && info_r.exec && clk_mod_r == 3'd0 &&
                  complete;
  wire wel_ok = !info_r.need_wel || wel_r ||
                (op_r == `OP_WR_SR && vol_en_r);
  wire exec_ok = frame_ok && wel_ok;
  wire frame_end = cs_rise && state_r != ST_IDLE;

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bp_r <= `BP_RST;
      {srp1_r, srp0_r, qe_r, lock_r} <= 5'h00;
      cmp_r <= `COMP_RST;
      dmy_cfg_r <= `DMY_CFG_RST;
      susp_r <= 1'b0;
      wel_r <= 1'b0;
      vol_en_r <= 1'b0;
      rst_arm_r <= 1'b0;
    end
    else
    begin
      if (i_op_done)
        wel_r <= 1'b0;
      if (frame_end)
      begin
        vol_en_r <= exec_ok && op_r == `OP_VOL_EN;
        rst_arm_r <= exec_ok && op_r == `OP_RST_EN;
      end
      if (exec_ok)
      begin
        case (op_r)
          `OP_WR_EN:
            wel_r <= 1'b1;
          `OP_WR_DIS:
            if (!i_write_in_progress)
              wel_r <= 1'b0;
          `OP_WR_SR:
          begin
            {srp0_r, bp_r} <= sr_lo_r[7:2];
            // A single byte clears the quad and complement bits
            cmp_r <= (byte_cnt_r == 2'd2) && sr_hi_r[6];
            qe_r <= (byte_cnt_r == 2'd2) && sr_hi_r[1];
            if (byte_cnt_r == 2'd2)
            begin
              dmy_cfg_r <= sr_hi_r[4];
              lock_r <= lock_r | sr_hi_r[3:2];
              srp1_r <= sr_hi_r[0];
            end
          end
          `OP_SUSPEND:
            susp_r <= 1'b1;
          `OP_RESUME:
            susp_r <= 1'b0;
          `OP_RST:
            if (rst_arm_r)
            begin
              susp_r <= 1'b0;
              wel_r <= 1'b0;
            end
          default:
            susp_r <= susp_r;
        endcase
      end
    end
  end

  // Reserved S13 always reads back as zero
  assign o_status = {susp_r, cmp_r, 1'b0, dmy_cfg_r, lock_r, qe_r, srp1_r,
                     srp0_r, bp_r, wel_r, i_write_in_progress};

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_exec_valid <= 1'b0;
      o_reject <= 1'b0;
      o_exec_code <= 8'h00;
      o_exec_addr <= 24'h000000;
      o_wrap_cfg <= 8'h00;
      o_pp_overrun <= 1'b0;
    end
    else
    begin
      o_exec_valid <= exec_ok;
      o_reject <= frame_end && info_r.exec && !exec_ok;
      if (exec_ok)
      begin
        o_exec_code <= op_r;
        o_exec_addr <= addr_r;
      end
      if (exec_ok && op_r == `OP_WRAP)
        o_wrap_cfg <= sr_lo_r;
      // The link cannot be stalled, so a full FIFO loses the byte
      if (byte_done && is_pp && !fifo_in_ready)
        o_pp_overrun <= 1'b1;
      else if (cs_fall)
        o_pp_overrun <= 1'b0;
    end
  end

  sfd_fifo #(.WIDTH(`PP_FIFO_W), .DEPTH(`PP_FIFO_D)) i_sfd_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_in_data(din_sh),
    .i_in_valid(byte_done && is_pp),
    .o_in_ready(fifo_in_ready),
    .o_out_data(o_pp_data),
    .o_out_valid(o_pp_valid),
    .i_out_ready(i_pp_ready)
  );

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_dual_mode_end;
    sclk_rise && state_r == ST_MODE && ph_cnt_r == 5'd0 &&
      op_r == `OP_DUAL_IO;
  endsequence
  sequence s_quad_mode_end;
    sclk_rise && state_r == ST_MODE && ph_cnt_r == 5'd0 &&
      op_r == `OP_QUAD_IO;
  endsequence

  AST_MSB_FIRST: assert property (sclk_rise && state_r == ST_OPC |=>
    op_r[0] == $past(io_s[0])) else $error("opcode bit order wrong");
  AST_OPC_START: assert property (cs_fall |=> state_r == ST_OPC &&
    ph_cnt_r == 5'd7) else $error("frame did not open with opcode");
  AST_DESELECT: assert property (cs_rise |=> state_r == ST_IDLE &&
    o_io_oe == 4'h0) else $error("not deselected after chip select");
  AST_BOUNDARY: assert property (o_exec_valid |->
    $past(clk_mod_r) == 3'd0 && $past(cs_rise))
    else $error("executed off a byte boundary");
  AST_PP_PARTIAL: assert property (cs_rise && is_pp &&
    clk_mod_r != 3'd0 && !i_op_done |=> !o_exec_valid && $stable(wel_r))
    else $error("partial program byte acted");
  AST_COMP_WRITE: assert property (exec_ok && op_r == `OP_WR_SR &&
    byte_cnt_r == 2'd2 |=> cmp_r == $past(sr_hi_r[6]))
    else $error("complement bit not written");
  AST_SUSP_SET: assert property (exec_ok && op_r == `OP_SUSPEND |=>
    susp_r && o_status[15]) else $error("suspend flag not set");
  AST_SUSP_CLR: assert property (exec_ok && (op_r == `OP_RESUME ||
    (op_r == `OP_RST && rst_arm_r)) |=> !susp_r)
    else $error("suspend flag not cleared");
  AST_DUAL_DMY: assert property (s_dual_mode_end |=>
    (dmy_cfg_r && state_r == ST_DUMMY && ph_cnt_r == 5'd3) ||
    (!dmy_cfg_r && state_r == ST_DOUT)) else $error("dual dummy count");
  AST_QUAD_DMY: assert property (s_quad_mode_end |=>
    state_r == ST_DUMMY && ph_cnt_r == (dmy_cfg_r ? 5'd7 : 5'd3))
    else $error("quad dummy count");
  AST_STATUS_RD: assert property (load_ev && op_r == `OP_RD_SR_HI |=>
    out_sh_r == $past(o_status[15:8])) else $error("status byte wrong");
  AST_ERASE_ADDR: assert property (sclk_rise && state_r == ST_OPC &&
    ph_cnt_r == 5'd0 && op_nxt == `OP_SE |=> state_r == ST_ADDR &&
    ph_cnt_r == 5'd23) else $error("erase address length wrong");
  AST_WEL_GATE: assert property (o_exec_valid &&
    $past(info_r.need_wel) |-> $past(wel_r) || $past(vol_en_r))
    else $error("write executed without latch");
  AST_IGNORE: assert property (state_r == ST_IGNORE && !cs_n_s |=>
    state_r == ST_IGNORE && !o_exec_valid) else $error("ignored frame ran");
endmodule : serial_flash_command_decoder

// ---- sfd_cfg.svh ----
// Opcodes, status reset values and counts for the flash decoder
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH
`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_RD_SR_LO 8'h05
`define OP_RD_SR_HI 8'h35
`define OP_WR_SR 8'h01
`define OP_VOL_EN 8'h50
`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_DUAL_OUT 8'h3b
`define OP_QUAD_OUT 8'h6b
`define OP_DUAL_IO 8'hbb
`define OP_QUAD_IO 8'heb
`define OP_WRAP 8'h77
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_SE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hd8
`define OP_CE_A 8'hc7
`define OP_CE_B 8'h60
`define OP_MFG_ID 8'h90
`define OP_JEDEC_ID 8'h9f
`define OP_UID 8'h4b
`define OP_SEC_ER 8'h44
`define OP_SEC_PR 8'h42
`define OP_SEC_RD 8'h48
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_PWR_DN 8'hb9
`define OP_PWR_UP 8'hab
`define OP_SFDP 8'h5a
`define BP_RST 5'h00
`define COMP_RST 1'b0
`define DMY_CFG_RST 1'b0
`define DMY_NONE 5'h00
`define DMY_QIO 5'h04
`define DMY_BYTE 5'h08
`define DMY_EXTRA 5'h04
`define ADDR_BITS 6'h18
`define BYTE_BITS 6'h08
`define PP_FIFO_W 8
`define PP_FIFO_D 8
`endif

// ---- sfd_host.sv ----
// Host-side SPI controller model driving the flash pins
`timescale 1ns/1ps
module sfd_host (
  input wire logic i_clk,
  input wire logic [3:0] i_dq,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
  end
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask : half
  // Clock stands low outside frames; released lines flip
  task automatic sel(input logic on);
    half();
    o_cs_n = ~on;
    if (!on)
      o_io = ~o_io;
    half();
  endtask : sel
  task automatic shift(input logic [63:0] v, input int n, input int w,
                       inout logic [31:0] r);
    for (int i = n - 1; i >= 0; i--)
    begin
      case (w)
        1: o_io[0] = v[i];
        2: o_io[1:0] = v[2*i+:2];
        default: o_io = v[4*i+:4];
      endcase
      half();
      o_sclk = 1'b1;
      r = (r << w) | (w == 1 ? i_dq[1] : (w == 2 ? i_dq[1:0] : i_dq));
      half();
      o_sclk = 1'b0;
    end
  endtask : shift
endmodule : sfd_host

// ---- sfd_pkg.sv ----
// Types shared by the flash command decoder
package sfd_pkg;
  // Lanes used: 0 one line, 1 two lines, 2 four lines
  typedef logic [1:0] lane_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DIN, ST_DOUT, ST_END,
    ST_IGNORE
  } state_t;
  typedef struct packed {
    logic has_addr;
    lane_t aw;
    logic has_mode;
    logic [4:0] dmy;
    logic dmy_ext;
    logic din;
    lane_t dw;
    logic dout;
    lane_t ow;
    logic exec;
    logic need_wel;
  } cmd_info_t;
endpackage : sfd_pkg

// ---- tb_serial_flash_command_decoder.sv ----
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module tb_serial_flash_command_decoder;
  logic i_core_clk, i_resetn, i_write_in_progress, i_op_done, i_pp_ready;
  logic cs_n, sclk, o_rd_strobe, o_exec_valid, o_reject;
  logic o_pp_valid, o_pp_overrun;
  logic [3:0] host_io, dq, o_io, o_io_oe;
  logic [23:0] o_rd_addr, o_exec_addr;
  logic [7:0] i_rd_data, o_exec_code, o_pp_data, o_wrap_cfg, last_code;
  logic [15:0] o_status;
  logic [31:0] r;
  logic [7:0] ops [5] = '{8'h75, 8'h7a, 8'h75, 8'h66, 8'h99};
  logic suspend_flag [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  int num_errors, comparisons, cnt;
  int n_rej = 0;
  int n_strb = 0;
  // Pin level from whoever drives it
  assign dq = (o_io & o_io_oe) | (host_io & ~o_io_oe);
  // Array contents follow the address, so a wrong address shows
  assign i_rd_data = o_rd_addr[7:0] ^ 8'h5a;
  serial_flash_command_decoder i_serial_flash_command_decoder (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_io(dq), .o_io(o_io), .o_io_oe(o_io_oe),
    .i_write_in_progress(i_write_in_progress), .i_op_done(i_op_done),
    .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
    .o_rd_strobe(o_rd_strobe), .o_exec_valid(o_exec_valid),
    .o_exec_code(o_exec_code), .o_exec_addr(o_exec_addr),
    .o_reject(o_reject), .o_pp_data(o_pp_data), .o_pp_valid(o_pp_valid),
    .i_pp_ready(i_pp_ready), .o_pp_overrun(o_pp_overrun),
    .o_wrap_cfg(o_wrap_cfg), .o_status(o_status));
  sfd_host i_sfd_host (.i_clk(i_core_clk), .i_dq(dq), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_io(host_io));
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
  begin
    if (o_exec_valid === 1'b1)
      last_code <= o_exec_code;
    if (o_reject === 1'b1)
      n_rej <= n_rej + 1;
    if (o_rd_strobe === 1'b1)
      n_strb <= n_strb + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [7:0] op, input logic [63:0] a,
                       input int an, input int w, input int dn, input int rn);
    i_sfd_host.sel(1'b1);
    i_sfd_host.shift(op, 8, 1, r);
    i_sfd_host.shift(a, an, w, r);
    i_sfd_host.shift(0, dn, w, r);
    r = 0;
    i_sfd_host.shift(0, rn, w, r);
    i_sfd_host.sel(1'b0);
    repeat (8) @(negedge i_core_clk);
  endtask : frame
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Whole run is well under 300 us
  initial
  begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    {i_resetn, i_write_in_progress, i_op_done, i_pp_ready} = 4'h0;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(negedge i_core_clk);
    i_resetn = 1'b1;
    chk(o_status, 16'h0000);
    frame(8'h06, 0, 0, 1, 0, 0);
    chk({o_status[1], last_code}, {1'b1, 8'h06});
    frame(8'h05, 0, 0, 1, 0, 16);
    chk(r, 32'h0202);
    frame(8'hbb, 24'h000040, 12, 2, 4, 8);
    chk(r, 32'h1a1b);
    frame(8'heb, 24'h000050, 6, 4, 6, 4);
    chk(r, 32'h0a0b);
    frame(8'h01, 16'h0050, 16, 1, 0, 0);
    frame(8'h35, 0, 0, 1, 0, 8);
    chk(r, 32'h50);
    i_op_done = 1'b1;
    @(negedge i_core_clk);
    i_op_done = 1'b0;
    frame(8'h20, 24'h001000, 24, 1, 0, 0);
    frame(8'h06, 0, 1, 1, 0, 0);
    chk({n_rej[30:0], o_status[1]}, {31'd2, 1'b0});
    cnt = n_strb;
    frame(8'h03, 24'h000010, 24, 1, 0, 16);
    chk(r, 32'h4a4b);
    // Last falling edge already prefetches a third byte
    chk(n_strb - cnt, 3);
    chk(o_rd_addr, 24'h000013);
    frame(8'h0b, 24'h000060, 24, 1, 8, 8);
    chk(r, 32'h3a);
    frame(8'hbb, 24'h000020, 12, 2, 8, 8);
    chk(r, 32'h7a7b);
    frame(8'heb, 24'h000030, 6, 4, 10, 4);
    chk(r, 32'h6a6b);
    for (int k = 0; k < 5; k++)
    begin
      frame(ops[k], 0, 0, 1, 0, 0);
      chk(o_status[15], suspend_flag[k]);
    end
    frame(8'h06, 0, 0, 1, 0, 0);
    i_sfd_host.sel(1'b1);
    i_sfd_host.shift(8'h02, 8, 1, r);
    i_sfd_host.shift(24'h000100, 24, 1, r);
    for (int k = 0; k < 9; k++)
      i_sfd_host.shift(8'hc0 + k, 8, 1, r);
    i_sfd_host.shift(0, 3, 1, r);
    i_sfd_host.sel(1'b0);
    repeat (8) @(negedge i_core_clk);
    chk({o_pp_overrun, o_pp_valid, o_status[1], o_pp_data}, 11'h7c0);
    chk(n_rej, 3);
    i_pp_ready = 1'b1;
    cnt = 0;
    repeat (12)
    begin
      if (o_pp_valid === 1'b1)
      begin
        chk(o_pp_data, 8'hc0 + cnt);
        cnt++;
      end
      @(negedge i_core_clk);
    end
    i_pp_ready = 1'b0;
    chk(cnt, 8);
    frame(8'h77, 32'h000000a5, 8, 4, 0, 0);
    chk({o_wrap_cfg, last_code}, {8'ha5, 8'h77});
    frame(8'h20, 24'h012345, 24, 1, 0, 0);
    chk({o_exec_addr, last_code}, {24'h012345, 8'h20});
    // Trailing write-enable byte must not run after an unknown opcode
    frame(8'hff, 8'h06, 8, 1, 0, 0);
    chk({n_rej[7:0], last_code}, {8'd3, 8'h20});
    i_write_in_progress = 1'b1;
    frame(8'h04, 0, 0, 1, 0, 0);
    chk(o_status[1:0], 2'b11);
    i_write_in_progress = 1'b0;
    frame(8'h04, 0, 0, 1, 0, 0);
    chk(o_status[1:0], 2'b00);
    frame(8'h50, 0, 0, 1, 0, 0);
    frame(8'h01, 16'h0000, 16, 1, 0, 0);
    chk({o_status[15:8], last_code}, {8'h00, 8'h01});
    print_verdict();
  end
endmodule : tb_serial_flash_command_decoder
